// ===== verilog/uif_irq_flags.sv
// USB function interrupt flag registers behind an AHB-Lite slave.
// Assumes endpoint engines and the serial engine deliver one-cycle event
// pulses on hclk, and a single AHB-Lite master with word transfers.
//
// What this block does
// (R1) IN flags: control endpoint bit0, endpoints bits1-3
// (R2) reading IN flags clears them all
// (R3) OUT flags bits1-3, bit0 reads zero
// (R4) reading OUT flags clears them all
// (R5) frame-start token sets bus flag bit3
// (R6) frame-start tick filled in when token missed
// (R7) bus reset detection sets bit2
// (R8) resume sets bit1 only while suspended
// (R9) suspend sets bit0 only if detection enabled
// (R10) reading bus flags clears all four
// (R11) bits 7:4 read zero, writes ignored
// (R12) interrupt raised while any enabled flag pending
// (R13) IN enables at index 0x07, same layout
// (R14) flags reset zero, event beats clearing read
// (R15) software keeps each value it read
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uif_irq_flags #(
   parameter int unsigned SOF_WAIT_CYCLES = uif_pkg::SOF_WAIT_CYC
) (
   input wire logic hclk, // system clock, 40 MHz
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // word transfers only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // always ready
   output logic hresp, // always okay
   input wire logic [3:0] in_ep_evt, // control and IN endpoint 1-3 pulses
   input wire logic [2:0] out_ep_evt, // OUT endpoint 1-3 event pulses
   input wire uif_pkg::uif_bus_evt_t bus_evt, // serial engine bus events
   input wire logic suspend_mode, // controller is suspended
   output logic sleep_detect_enable, // suspend detection enabled
   output logic usb_irq // interrupt request, active high
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   uif_pkg::uif_aphase_t aph_r;
   uif_pkg::uif_aphase_t aph_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;
   logic [3:0] in_en_r;
   logic [3:0] in_en_nxt;
   logic [2:0] out_en_r;
   logic [2:0] out_en_nxt;
   logic [3:0] bus_en_r;
   logic [3:0] bus_en_nxt;
   logic sleep_en_r;
   logic sleep_en_nxt;
   logic irq_r;
   logic irq_nxt;

   logic [3:0] in_flags;
   logic [2:0] out_flags;
   logic [3:0] bus_flags;
   logic [3:0] in_set;
   logic [2:0] out_set;
   logic [3:0] bus_set;
   logic [3:0] in_clr;
   logic [2:0] out_clr;
   logic [3:0] bus_clr;
   logic rd_take;
   logic wr_now;
   logic clr_wr;
   logic sof_tick;
   logic [7:0] a_lo;

   assign a_lo = haddr[7:0];
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   assign wr_now = aph_r.valid && aph_r.write;
   assign clr_wr = wr_now && (aph_r.addr == uif_pkg::ADDR_FLAG_CLR);

   // ----------------------------------------------------------------
   // event sources
   // ----------------------------------------------------------------
   uif_sof_timer #(
      .WAIT_CYC(SOF_WAIT_CYCLES)
   ) u_sof (
      .clk(hclk),
      .rstn(hresetn),
      .sof_token(bus_evt.sof_token),
      .stop(bus_evt.bus_reset || bus_evt.suspend),
      .tick(sof_tick)
   );

   always_comb begin
      in_set = in_ep_evt; // [R1]
      out_set = out_ep_evt; // [R3]
      bus_set = '0;
      bus_set[uif_pkg::BUS_SOF_BIT] = sof_tick; // [R5] [R6]
      bus_set[uif_pkg::BUS_RESET_BIT] = bus_evt.bus_reset; // [R7]
      bus_set[uif_pkg::BUS_WAKE_BIT] = bus_evt.resume && suspend_mode; // [R8]
      bus_set[uif_pkg::BUS_SLEEP_BIT] = bus_evt.suspend && sleep_en_r; // [R9]
   end

   // clears act on the address phase of a read, so the data phase returns
   // the value from before the clear; writes to a flag word are ignored
   always_comb begin
      in_clr = {4{rd_take && (a_lo == uif_pkg::ADDR_IN_FLAGS)}}; // [R2]
      out_clr = {3{rd_take && (a_lo == uif_pkg::ADDR_OUT_FLAGS)}}; // [R4]
      bus_clr = {4{rd_take && (a_lo == uif_pkg::ADDR_BUS_FLAGS)}}; // [R10]
      if (clr_wr) begin
         in_clr = in_clr | hwdata[uif_pkg::CLR_IN_LSB +: 4];
         out_clr = out_clr | hwdata[uif_pkg::CLR_OUT_LSB +: 3];
         bus_clr = bus_clr | hwdata[uif_pkg::CLR_BUS_LSB +: 4];
      end
   end

   // each bank lets a same-cycle set win over its clear [R14]
   uif_flag_bank #(.W(4)) u_in_bank (
      .clk(hclk),
      .rstn(hresetn),
      .set(in_set),
      .clr(in_clr),
      .flags(in_flags)
   );

   uif_flag_bank #(.W(3)) u_out_bank (
      .clk(hclk),
      .rstn(hresetn),
      .set(out_set),
      .clr(out_clr),
      .flags(out_flags)
   );

   uif_flag_bank #(.W(4)) u_bus_bank (
      .clk(hclk),
      .rstn(hresetn),
      .set(bus_set),
      .clr(bus_clr),
      .flags(bus_flags)
   );

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   // zero wait states: read data is registered at the address phase
   always_comb begin
      aph_nxt.valid = hsel && htrans[1] && hready;
      aph_nxt.write = hwrite;
      aph_nxt.addr = a_lo;
      hrdata_nxt = 32'h00000000;
      if (rd_take) begin
         unique case (a_lo)
            uif_pkg::ADDR_IN_FLAGS: hrdata_nxt = {28'h0000000, in_flags}; // [R1] [R11]
            uif_pkg::ADDR_OUT_FLAGS: hrdata_nxt = {28'h0000000, out_flags, 1'b0}; // [R3] [R11]
            uif_pkg::ADDR_BUS_FLAGS: hrdata_nxt = {28'h0000000, bus_flags}; // [R11]
            uif_pkg::ADDR_IN_EN: hrdata_nxt = {28'h0000000, in_en_r}; // [R13]
            uif_pkg::ADDR_OUT_EN: hrdata_nxt = {28'h0000000, out_en_r, 1'b0};
            uif_pkg::ADDR_BUS_EN: hrdata_nxt = {28'h0000000, bus_en_r};
            uif_pkg::ADDR_CTRL: hrdata_nxt = {31'h0, sleep_en_r};
            default: hrdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_comb begin
      in_en_nxt = in_en_r;
      out_en_nxt = out_en_r;
      bus_en_nxt = bus_en_r;
      sleep_en_nxt = sleep_en_r;
      if (wr_now) begin
         unique case (aph_r.addr)
            uif_pkg::ADDR_IN_EN: in_en_nxt = hwdata[3:0]; // [R13]
            uif_pkg::ADDR_OUT_EN: out_en_nxt = hwdata[3:1];
            uif_pkg::ADDR_BUS_EN: bus_en_nxt = hwdata[3:0];
            uif_pkg::ADDR_CTRL: sleep_en_nxt = hwdata[uif_pkg::CTRL_SLEEP_EN_BIT];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupt
   // ----------------------------------------------------------------
   // flags gated by their enables; all enables at one give any-flag irq
   always_comb begin
      irq_nxt = |(in_flags & in_en_r) | |(out_flags & out_en_r) |
                |(bus_flags & bus_en_r); // [R12] [R13]
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_r <= '0;
         hrdata_r <= 32'h00000000;
         in_en_r <= uif_pkg::IN_EN_RST;
         out_en_r <= uif_pkg::OUT_EN_RST;
         bus_en_r <= uif_pkg::BUS_EN_RST;
         sleep_en_r <= uif_pkg::SLEEP_EN_RST;
         irq_r <= 1'b0;
      end else begin
         aph_r <= aph_nxt;
         hrdata_r <= hrdata_nxt;
         in_en_r <= in_en_nxt;
         out_en_r <= out_en_nxt;
         bus_en_r <= bus_en_nxt;
         sleep_en_r <= sleep_en_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign sleep_detect_enable = sleep_en_r;
   assign usb_irq = irq_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_in_read_value: assert property ( // [R1]
      (rd_take && a_lo == uif_pkg::ADDR_IN_FLAGS) |=>
         hrdata_r == {28'h0000000, $past(in_flags)})
      else $error("IN flag read returned wrong value");

   chk_in_read_clear: assert property ( // [R2]
      (rd_take && a_lo == uif_pkg::ADDR_IN_FLAGS && in_set == 4'h0) |=>
         in_flags == 4'h0)
      else $error("IN flags not cleared by read");

   chk_out_bit_zero: assert property ( // [R3]
      (rd_take && a_lo == uif_pkg::ADDR_OUT_FLAGS) |=>
         (hrdata_r[0] == 1'b0) && (hrdata_r[3:1] == $past(out_flags)))
      else $error("OUT flag read returned wrong value");

   chk_out_read_clear: assert property ( // [R4]
      (rd_take && a_lo == uif_pkg::ADDR_OUT_FLAGS && out_set == 3'h0) |=>
         out_flags == 3'h0)
      else $error("OUT flags not cleared by read");

   chk_sof_flag_set: assert property ( // [R5]
      bus_evt.sof_token |-> ##2 bus_flags[uif_pkg::BUS_SOF_BIT])
      else $error("frame-start token did not set its flag");

   chk_reset_flag_set: assert property ( // [R7]
      bus_evt.bus_reset |=> bus_flags[uif_pkg::BUS_RESET_BIT])
      else $error("bus reset did not set its flag");

   chk_wake_only_suspended: assert property ( // [R8]
      $rose(bus_flags[uif_pkg::BUS_WAKE_BIT]) |->
         $past(bus_evt.resume) && $past(suspend_mode))
      else $error("resume flag set outside suspend");

   chk_sleep_needs_enable: assert property ( // [R9]
      $rose(bus_flags[uif_pkg::BUS_SLEEP_BIT]) |->
         $past(bus_evt.suspend) && $past(sleep_en_r))
      else $error("suspend flag set while detection off");

   chk_bus_read_clear: assert property ( // [R10]
      (rd_take && a_lo == uif_pkg::ADDR_BUS_FLAGS && bus_set == 4'h0) |=>
         bus_flags == 4'h0)
      else $error("bus flags not cleared by read");

   chk_upper_bits_zero: assert property ( // [R11]
      aph_r.valid && !aph_r.write |-> hrdata_r[31:4] == 28'h0000000)
      else $error("upper read bits not zero");

   chk_irq_follows: assert property ( // [R12]
      (|(in_flags & in_en_r)) ##1 (|(in_flags & in_en_r)) |-> usb_irq)
      else $error("irq low with enabled flag pending");

   chk_event_survives: assert property ( // [R14]
      (in_set[0] && in_clr[0]) |=> in_flags[0])
      else $error("event lost on clearing read");

   chk_irq_other_flags: assert property ( // [R12]
      (|(out_flags & out_en_r) || |(bus_flags & bus_en_r)) |=> usb_irq)
      else $error("irq low with enabled OUT or bus flag pending");

   // the mask must also pull the request down, not only let it up
   chk_irq_masked_low: assert property ( // [R13]
      !(|(in_flags & in_en_r) || |(out_flags & out_en_r) || |(bus_flags & bus_en_r)) |=>
         !usb_irq)
      else $error("irq high with no enabled flag pending");

   cov_read_pending: cover property (
      (rd_take && a_lo == uif_pkg::ADDR_IN_FLAGS && in_flags != 4'h0));
   cov_sof_filled_in: cover property (
      sof_tick && !$past(bus_evt.sof_token));
   cov_irq_rise: cover property ($rose(usb_irq));
   cov_set_on_clear: cover property (bus_set != 4'h0 && bus_clr != 4'h0);
endmodule
`default_nettype wire

// ===== verilog/uif_pkg.sv
// USB function interrupt flag block: shared constants and carrier types.
// Assumes a 40 MHz hclk and registers reached as 32-bit AHB-Lite words.
package uif_pkg;

   // ----------------------------------------------------------------
   // register indices and byte addresses (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam int IDX_IN_FLAGS = 2;
   localparam int IDX_OUT_FLAGS = 4;
   localparam int IDX_BUS_FLAGS = 6;
   localparam int IDX_IN_EN = 7;
   localparam int IDX_OUT_EN = 9;
   localparam int IDX_BUS_EN = 11;
   localparam int IDX_CTRL = 16;
   localparam int IDX_FLAG_CLR = 17;
   localparam logic [7:0] ADDR_IN_FLAGS = 8'(4 * IDX_IN_FLAGS);
   localparam logic [7:0] ADDR_OUT_FLAGS = 8'(4 * IDX_OUT_FLAGS);
   localparam logic [7:0] ADDR_BUS_FLAGS = 8'(4 * IDX_BUS_FLAGS);
   localparam logic [7:0] ADDR_IN_EN = 8'(4 * IDX_IN_EN);
   localparam logic [7:0] ADDR_OUT_EN = 8'(4 * IDX_OUT_EN);
   localparam logic [7:0] ADDR_BUS_EN = 8'(4 * IDX_BUS_EN);
   localparam logic [7:0] ADDR_CTRL = 8'(4 * IDX_CTRL);
   localparam logic [7:0] ADDR_FLAG_CLR = 8'(4 * IDX_FLAG_CLR);

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int BUS_SOF_BIT = 3;
   localparam int BUS_RESET_BIT = 2;
   localparam int BUS_WAKE_BIT = 1;
   localparam int BUS_SLEEP_BIT = 0;
   localparam int CTRL_SLEEP_EN_BIT = 0;
   localparam int CLR_IN_LSB = 0;
   localparam int CLR_OUT_LSB = 9;
   localparam int CLR_BUS_LSB = 16;
   localparam logic [3:0] IN_EN_RST = 4'hF;
   localparam logic [2:0] OUT_EN_RST = 3'h7;
   localparam logic [3:0] BUS_EN_RST = 4'h6;
   localparam logic SLEEP_EN_RST = 1'h0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int FRAME_NS = 1000000;
   localparam int SOF_SLACK_NS = 2000;
   localparam int SOF_WAIT_CYC = (FRAME_NS + SOF_SLACK_NS) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sof_token;
      logic bus_reset;
      logic resume;
      logic suspend;
   } uif_bus_evt_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } uif_aphase_t;

   typedef enum logic {
      SOF_IDLE = 1'b0,
      SOF_TRACK = 1'b1
   } uif_sof_state_t;

endpackage

// ===== verilog/uif_flag_bank.sv
// Bank of sticky pending flags with a per-bit clear.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module uif_flag_bank #(
   parameter int W = 4
) (
   input wire logic clk, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic [W-1:0] set, // one-cycle event pulses
   input wire logic [W-1:0] clr, // one-cycle clear pulses
   output logic [W-1:0] flags // pending flags
);
   logic [W-1:0] flags_r;
   logic [W-1:0] flags_nxt;

   // set beats clear so an event landing on a clearing read is kept
   always_comb begin
      flags_nxt = (flags_r & ~clr) | set;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_r <= '0;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags = flags_r;
endmodule
`default_nettype wire

// ===== verilog/uif_sof_timer.sv
// Frame-start tick generator: passes real frame-start tokens through and
// fills in a tick when an expected token fails to arrive.
// Assumes sof_token and stop are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module uif_sof_timer #(
   parameter int unsigned WAIT_CYC = 40080
) (
   input wire logic clk, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic sof_token, // good frame-start token seen
   input wire logic stop, // bus reset or suspend: stop filling in
   output logic tick // one-cycle frame-start pulse
);
   localparam int CW = $clog2(WAIT_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(WAIT_CYC - 1);

   uif_pkg::uif_sof_state_t state_r;
   uif_pkg::uif_sof_state_t state_nxt;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   // no filling in until a first real token gives the frame phase
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      unique case (state_r)
         uif_pkg::SOF_IDLE: begin
            if (sof_token) begin
               state_nxt = uif_pkg::SOF_TRACK;
               cnt_nxt = '0;
               tick_nxt = 1'b1;
            end
         end
         uif_pkg::SOF_TRACK: begin
            if (stop) begin
               state_nxt = uif_pkg::SOF_IDLE;
               cnt_nxt = '0;
               // a real token on the stop cycle must still reach its flag
               tick_nxt = sof_token; // [R5]
            end else if (sof_token) begin
               cnt_nxt = '0;
               tick_nxt = 1'b1;
            end else if (cnt_r == LAST) begin
               cnt_nxt = '0;
               tick_nxt = 1'b1; // [R6]
            end else begin
               cnt_nxt = cnt_r + CW'(1);
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= uif_pkg::SOF_IDLE;
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule
`default_nettype wire

// ===== verification/uif_evt_host.sv
// Far-side event source: stands in for the host traffic as decoded by the
// serial engine and the endpoint engines, as one-cycle pulses on hclk.
// Assumes the bench calls its tasks one at a time, from a single process.
`timescale 1ns/1ps
`default_nettype none
module uif_evt_host (
   input wire logic hclk, // system clock
   output logic [3:0] in_ep_evt, // control and IN endpoint 1-3 pulses
   output logic [2:0] out_ep_evt, // OUT endpoint 1-3 event pulses
   output uif_pkg::uif_bus_evt_t bus_evt, // bus event pulses
   output logic suspend_mode // controller suspended level
);
   initial begin
      in_ep_evt = 4'h0;
      out_ep_evt = 3'h0;
      bus_evt = uif_pkg::uif_bus_evt_t'(4'h0);
      suspend_mode = 1'b0;
   end

   // ----------------------------------------------------------------
   // one-cycle pulses and the suspend level, launched just after a rising edge
   // ----------------------------------------------------------------
   task automatic pulse(input logic [3:0] i, input logic [2:0] o, input logic [3:0] b);
      @(posedge hclk);
      in_ep_evt <= i;
      out_ep_evt <= o;
      bus_evt <= uif_pkg::uif_bus_evt_t'(b);
      @(posedge hclk);
      in_ep_evt <= 4'h0;
      out_ep_evt <= 3'h0;
      bus_evt <= uif_pkg::uif_bus_evt_t'(4'h0);
   endtask

   task automatic set_susp(input logic s);
      @(posedge hclk);
      suspend_mode <= s;
   endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the interrupt flag block: AHB-Lite master tasks,
// an event source model, and a monitor that pops expected read data.
// Assumes zero-wait slave behaviour is not relied on: every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int WAIT = 50;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   wire logic hready;
   logic [3:0] in_ep_evt;
   logic [2:0] out_ep_evt;
   uif_pkg::uif_bus_evt_t bus_evt;
   logic suspend_mode;
   logic sleep_detect_enable;
   logic usb_irq;
   logic rd_phase = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] v;
   int num_errors = 0;
   int checks_done = 0;
   int seed = 38239;

   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;

   uif_irq_flags #(.SOF_WAIT_CYCLES(WAIT)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .in_ep_evt(in_ep_evt), .out_ep_evt(out_ep_evt), .bus_evt(bus_evt),
      .suspend_mode(suspend_mode), .sleep_detect_enable(sleep_detect_enable),
      .usb_irq(usb_irq));

   uif_evt_host host (.hclk(hclk), .in_ep_evt(in_ep_evt), .out_ep_evt(out_ep_evt),
      .bus_evt(bus_evt), .suspend_mode(suspend_mode));

   // ----------------------------------------------------------------
   // reporting
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // bus master
   // ----------------------------------------------------------------
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         num_errors++;
         give_verdict();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] e);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_phase <= !w;
      // the expected value is queued here for the monitor to check in the data phase
      if (!w) exp_q.push_back(e);
      wait_rdy();
      rd_phase <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // ----------------------------------------------------------------
   // monitor: read data stands in the data phase only
   // ----------------------------------------------------------------
   always @(posedge hclk) begin
      if (rd_phase && hready === 1'b1) begin
         if (exp_q.size() == 0) chk(hrdata, 32'hDEADBEEF);
         else chk(hrdata, exp_q.pop_front());
         chk({31'h0, hresp}, 32'h0);
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      cyc(2);
      hresetn <= 1'b1;
      chk({31'h0, usb_irq}, 32'h0);
      rd(uif_pkg::ADDR_IN_FLAGS, 32'h0);
      rd(uif_pkg::ADDR_OUT_FLAGS, 32'h0);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h0);
      rd(uif_pkg::ADDR_IN_EN, 32'hF);
      rd(uif_pkg::ADDR_OUT_EN, 32'hE);
      rd(uif_pkg::ADDR_BUS_EN, 32'h6);
      rd(uif_pkg::ADDR_CTRL, 32'h0);
      wr(8'h30, 32'hFFFFFFFF);
      rd(8'h30, 32'h0);
      for (int k = 0; k < 4; k++) begin
         v = $random(seed);
         host.pulse(v[3:0], v[6:4], 4'h0);
         cyc(2);
         chk({31'h0, usb_irq}, {31'h0, |v[6:0]});
         rd(uif_pkg::ADDR_IN_FLAGS, {28'h0, v[3:0]});
         rd(uif_pkg::ADDR_OUT_FLAGS, {28'h0, v[6:4], 1'b0});
         rd(uif_pkg::ADDR_IN_FLAGS, 32'h0);
         rd(uif_pkg::ADDR_OUT_FLAGS, 32'h0);
         chk({31'h0, usb_irq}, 32'h0);
      end
      host.pulse(4'hF, 3'h0, 4'h0);
      wr(uif_pkg::ADDR_IN_FLAGS, 32'hFFFFFFFF);
      rd(uif_pkg::ADDR_IN_FLAGS, 32'hF);
      // event landing in the clearing read's own cycle must survive it
      host.pulse(4'h2, 3'h0, 4'h0);
      fork
         rd(uif_pkg::ADDR_IN_FLAGS, 32'h2);
         host.pulse(4'h1, 3'h0, 4'h0);
      join
      rd(uif_pkg::ADDR_IN_FLAGS, 32'h1);
      host.pulse(4'h0, 3'h0, 4'h8);
      cyc(2);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h8);
      cyc(WAIT + 10);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h8);
      host.pulse(4'h0, 3'h0, 4'h4);
      cyc(2);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h4);
      cyc(2 * WAIT + 10);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h0);
      host.pulse(4'h0, 3'h0, 4'h2);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h0);
      host.set_susp(1'b1);
      host.pulse(4'h0, 3'h0, 4'h2);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h2);
      host.set_susp(1'b0);
      host.pulse(4'h0, 3'h0, 4'h1);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h0);
      wr(uif_pkg::ADDR_CTRL, 32'h1);
      // the enable lands at the data-phase edge; look one edge later
      cyc(1);
      chk({31'h0, sleep_detect_enable}, 32'h1);
      host.pulse(4'h0, 3'h0, 4'h1);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h1);
      wr(uif_pkg::ADDR_IN_EN, 32'hFFFFFFF0);
      rd(uif_pkg::ADDR_IN_EN, 32'h0);
      host.pulse(4'h8, 3'h0, 4'h0);
      cyc(2);
      chk({31'h0, usb_irq}, 32'h0);
      wr(uif_pkg::ADDR_IN_EN, 32'h8);
      cyc(2);
      chk({31'h0, usb_irq}, 32'h1);
      rd(uif_pkg::ADDR_IN_FLAGS, 32'h8);
      // the registered request drops one edge after the clearing read
      cyc(1);
      chk({31'h0, usb_irq}, 32'h0);
      host.pulse(4'h0, 3'h4, 4'h0);
      wr(uif_pkg::ADDR_FLAG_CLR, 32'h800);
      rd(uif_pkg::ADDR_OUT_FLAGS, 32'h0);
      rd(uif_pkg::ADDR_FLAG_CLR, 32'h0);
      // a mid-run reset must drop every pending flag and the request, and restore the IN enables to their reset value
      host.pulse(4'h5, 3'h2, 4'h4);
      cyc(1);
      hresetn <= 1'b0;
      cyc(2);
      hresetn <= 1'b1;
      chk({31'h0, usb_irq}, 32'h0);
      rd(uif_pkg::ADDR_IN_FLAGS, 32'h0);
      rd(uif_pkg::ADDR_OUT_FLAGS, 32'h0);
      rd(uif_pkg::ADDR_BUS_FLAGS, 32'h0);
      rd(uif_pkg::ADDR_IN_EN, 32'hF);
      give_verdict();
   end
endmodule
`default_nettype wire
